// file: hdl/ierb_pkg.sv
// constants for the interrupt enable and request bank
// assumes an 8-bit special function register port at 16-bit addresses
package ierb_pkg;

    // register map: eight enable bytes then eight request bytes
    localparam logic [15:0] IE_BASE_ADDR  = 16'hf010;
    localparam logic [15:0] IRQ_BASE_ADDR = 16'hf018;
    localparam int          BANK_BYTES    = 8;

    // addresses of the registers named in the map
    localparam logic [15:0] TIMER_GROUP_IRQ_ENABLE_ADDR      = 16'hf015;
    localparam logic [15:0] PWM_TICK_IRQ_ENABLE_ADDR         = 16'hf016;
    localparam logic [15:0] SLOW_TICK_IRQ_ENABLE_ADDR        = 16'hf017;
    localparam logic [15:0] WATCHDOG_SUPPLY_IRQ_REQUEST_ADDR = 16'hf018;
    localparam logic [15:0] PORT_PIN_IRQ_REQUEST_ADDR        = 16'hf019;
    localparam logic [15:0] CONVERTER_IRQ_REQUEST_ADDR       = 16'hf01a;
    localparam logic [15:0] TIMER_PAIR_IRQ_REQUEST_ADDR      = 16'hf01b;
    localparam logic [15:0] COMPARATOR_IRQ_ENABLE_ADDR       = 16'hf014;

    // implemented bits, byte n in bits 8n+7..8n
    localparam logic [63:0] IE_IMPL_MASK  = 64'h09a1_f0c1_0c04_3740;
    localparam logic [63:0] IRQ_IMPL_MASK = 64'h09a1_f0c1_0c04_3741;

    // reset value of every register
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [63:0] BANK_RESET    = 64'h0;

    // flat source index of the non-maskable watchdog flag
    localparam logic [5:0]  WATCHDOG_INDEX = 6'h00;

    // field positions inside their bytes
    localparam int TIMER_E_IRQ_EN_BIT         = 4;
    localparam int TIMER_F_IRQ_EN_BIT         = 5;
    localparam int TIMER_A_IRQ_EN_BIT         = 6;
    localparam int TIMER_B_IRQ_EN_BIT         = 7;
    localparam int PWM_C_IRQ_EN_BIT           = 0;
    localparam int TICK_128HZ_IRQ_EN_BIT      = 5;
    localparam int TICK_32HZ_IRQ_EN_BIT       = 7;
    localparam int TICK_16HZ_IRQ_EN_BIT       = 0;
    localparam int TICK_2HZ_IRQ_EN_BIT        = 3;
    localparam int COMPARATOR_ZERO_IRQ_EN_BIT = 6;
    localparam int COMPARATOR_ONE_IRQ_EN_BIT  = 7;
    localparam int WATCHDOG_IRQ_PENDING_BIT   = 0;
    localparam int SUPPLY_MONITOR_PENDING_BIT = 6;
    localparam int CONVERTER_IRQ_PENDING_BIT  = 2;
    localparam int TIMER_EIGHT_PENDING_BIT    = 2;
    localparam int TIMER_NINE_PENDING_BIT     = 3;
    localparam int PORT_A_PIN0_PENDING_BIT    = 0;
    localparam int PORT_A_PIN1_PENDING_BIT    = 1;
    localparam int PORT_A_PIN2_PENDING_BIT    = 2;
    localparam int PORT_B_PIN0_PENDING_BIT    = 4;
    localparam int PORT_B_PIN1_PENDING_BIT    = 5;
    localparam int UART_PENDING_BIT           = 0;

endpackage : ierb_pkg

// file: hdl/ierb_top.sv
// interrupt enable and request flag bank with cpu request outputs
// assumes peripherals and cpu run on i_clk; sfr port is single-cycle
// event inputs are single-cycle strobes from logic on the same clock, so no
// synchroniser stands in front of them
//
// The implementer's own choice: the address-and-strobe port.
module ierb_top (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic [63:0] i_src_event,
    input  wire logic        i_mie_set,
    input  wire logic        i_mie_clear,
    input  wire logic        i_instr_retire,
    input  wire logic        i_accept,
    input  wire logic [5:0]  i_accept_index,
    output logic             o_master_irq_enable,
    output logic             o_nmi_request,
    output logic             o_irq_request,
    output logic      [63:0] o_request_vec,
    output logic             o_write_hold
);

    ////////////////////////////////////////////////////////////////////
    // address decode

    // the bank covers sixteen consecutive bytes: eight enables, then eight requests
    // anything outside that window misses, so writes are dropped and reads give zero
    // {hit, request side, byte index}; shared by write and read paths
    function automatic logic [4:0] sfr_index(input logic [15:0] addr);
        logic [15:0] rel;
        rel = addr - ierb_pkg::IE_BASE_ADDR;
        if (rel < 16'(2 * ierb_pkg::BANK_BYTES)) begin
            sfr_index = {1'b1, rel[3:0]};
        end else begin
            sfr_index = 5'h00;
        end
    endfunction : sfr_index

    logic [4:0]  acc_sel;
    logic        wr_ie;
    logic        wr_irq;
    logic        rd_hit;

    assign acc_sel = sfr_index(i_addr);
    assign wr_ie   = i_wr & acc_sel[4] & ~acc_sel[3];
    assign wr_irq  = i_wr & acc_sel[4] & acc_sel[3];
    assign rd_hit  = i_rd & acc_sel[4];

    ////////////////////////////////////////////////////////////////////
    // implemented-bit masks per byte

    logic [63:0] ie_mask;
    logic [63:0] irq_mask;

    // implemented positions per byte, enables and requests alike:
    //   byte 0: supply monitor at bit 6; the request byte adds the watchdog at bit 0
    //   byte 1: port a pins 0 to 2 at bits 0 to 2, port b pins 0 and 1 at bits 4, 5
    //   byte 2: converter at bit 2
    //   byte 3: timer 8 at bit 2, timer 9 at bit 3
    //   byte 4: uart at bit 0, comparator zero at bit 6, comparator one at bit 7
    //   byte 5: timer e, f, a, b at bits 4 to 7
    //   byte 6: pwm c at bit 0, 128 hz tick at bit 5, 32 hz tick at bit 7
    //   byte 7: 16 hz tick at bit 0, 2 hz tick at bit 3
    // the watchdog has no enable bit: its enable position stays reserved
    // reserved positions are forced to zero through these masks, so a write
    // of all ones cannot wake a source that does not exist
    assign ie_mask[31:0]  = ierb_pkg::IE_IMPL_MASK[31:0];
    assign ie_mask[39:32] = ierb_pkg::IE_IMPL_MASK[39:32];
    assign ie_mask[47:40] = ierb_pkg::IE_IMPL_MASK[47:40];
    assign ie_mask[55:48] = ierb_pkg::IE_IMPL_MASK[55:48];
    assign ie_mask[63:56] = ierb_pkg::IE_IMPL_MASK[63:56];
    assign irq_mask[7:0]   = ierb_pkg::IRQ_IMPL_MASK[7:0];
    assign irq_mask[15:8]  = ierb_pkg::IRQ_IMPL_MASK[15:8];
    assign irq_mask[23:16] = ierb_pkg::IRQ_IMPL_MASK[23:16];
    assign irq_mask[31:24] = ierb_pkg::IRQ_IMPL_MASK[31:24];
    assign irq_mask[63:32] = ierb_pkg::IRQ_IMPL_MASK[63:32];

    ////////////////////////////////////////////////////////////////////
    // acceptance decode

    logic [63:0] accept_clr;

    // flat index is 8 * byte + bit, the same layout as i_src_event
    // an index on a reserved position clears nothing because the flag there
    // is held at zero by the request mask
    // one-hot clear for the source the cpu just took
    assign accept_clr = i_accept ? (64'h1 << i_accept_index) : 64'h0;

    ////////////////////////////////////////////////////////////////////
    // enable and request bytes

    logic [63:0] en_q;
    logic [63:0] flag_q;

    for (genvar g = 0; g < ierb_pkg::BANK_BYTES; g++) begin : g_byte
        logic       wr_en_hit;
        logic       wr_flag_hit;
        logic [7:0] en_d;
        logic [7:0] flag_keep;
        logic [7:0] flag_d;

        assign wr_en_hit   = wr_ie & (acc_sel[2:0] == 3'(g));
        assign wr_flag_hit = wr_irq & (acc_sel[2:0] == 3'(g));

        // enables are plain storage; the cpu accept never touches them, so a
        // handler returns with its source still enabled
        assign en_d = wr_en_hit ? (i_wdata & ie_mask[8*g +: 8])
                                : en_q[8*g +: 8];

        // a write replaces the byte, 1 acting as a trigger
        assign flag_keep = wr_flag_hit ? i_wdata
                                       : (flag_q[8*g +: 8] & ~accept_clr[8*g +: 8]);

        // event set beats software clear and accept clear: an event that lands
        // in the same cycle as a clear must not be lost
        assign flag_d = irq_mask[8*g +: 8] & (i_src_event[8*g +: 8] | flag_keep);

        // flags and enables start cleared
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                en_q[8*g +: 8]   <= ierb_pkg::REG_RESET;
                flag_q[8*g +: 8] <= ierb_pkg::REG_RESET;
            end else begin
                en_q[8*g +: 8]   <= en_d;
                flag_q[8*g +: 8] <= flag_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // master enable

    logic mie_q;
    logic mie_d;

    // accept wins over a set in the same cycle; cpu is entering a handler
    // and must not be re-entered by a set that was already in flight
    assign mie_d = i_accept ? 1'b0 : (i_mie_set ? 1'b1 : (i_mie_clear ? 1'b0 : mie_q));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mie_q <= 1'b0;
        end else begin
            mie_q <= mie_d;
        end
    end

    assign o_master_irq_enable = mie_q;

    ////////////////////////////////////////////////////////////////////
    // write hold: one instruction of grace after writing to the bank

    logic hold_q;
    logic hold_d;

    // the cpu may still be finishing the store when the flag appears; the
    // hold keeps the transfer back until one more instruction has retired
    // limitation: the hold also parks the watchdog for that instruction
    // a new write re-arms the hold even if a retire arrives alongside
    assign hold_d = (wr_ie | wr_irq) ? 1'b1 : (i_instr_retire ? 1'b0 : hold_q);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
        end
    end

    assign o_write_hold = hold_q;

    ////////////////////////////////////////////////////////////////////
    // request outputs

    logic [63:0] gate_vec;
    logic [63:0] live_vec;

    // watchdog bypasses both its enable and the master enable
    // its enable position is reserved, so no software path can mask it
    assign gate_vec = (en_q & {64{mie_q}}) | (64'h1 << ierb_pkg::WATCHDOG_INDEX);

    // all three terms must hold for a maskable source
    // a flag raised while masked waits here and fires once unmasked
    assign live_vec = flag_q & gate_vec;

    // requests are parked while the hold is up, watchdog included
    assign o_request_vec = hold_q ? 64'h0 : live_vec;

    ////////////////////////////////////////////////////////////////////
    // per-source request view

    // one named line per source keeps the flat vector reviewable
    // request byte 0
    logic watchdog_interrupt;
    logic supply_monitor_interrupt;

    // request byte 1
    logic port_a_pin0_interrupt;
    logic port_a_pin1_interrupt;
    logic port_a_pin2_interrupt;
    logic port_b_pin0_interrupt;
    logic port_b_pin1_interrupt;

    // request byte 2
    logic converter_interrupt;

    // request byte 3
    logic timer_eight_interrupt;
    logic timer_nine_interrupt;

    // request byte 4
    logic uart_interrupt;
    logic comparator_zero_interrupt;
    logic comparator_one_interrupt;

    // request byte 5
    logic timer_e_interrupt;
    logic timer_f_interrupt;
    logic timer_a_interrupt;
    logic timer_b_interrupt;

    // request byte 6
    logic pwm_c_interrupt;
    logic tick_128hz_interrupt;
    logic tick_32hz_interrupt;

    // request byte 7
    logic tick_16hz_interrupt;
    logic tick_2hz_interrupt;

    // byte 0: watchdog is non-maskable, supply monitor is maskable
    assign watchdog_interrupt       = o_request_vec[8*0 + ierb_pkg::WATCHDOG_IRQ_PENDING_BIT];
    assign supply_monitor_interrupt = o_request_vec[8*0 + ierb_pkg::SUPPLY_MONITOR_PENDING_BIT];

    // byte 1: port pin sources
    assign port_a_pin0_interrupt = o_request_vec[8*1 + ierb_pkg::PORT_A_PIN0_PENDING_BIT];
    assign port_a_pin1_interrupt = o_request_vec[8*1 + ierb_pkg::PORT_A_PIN1_PENDING_BIT];
    assign port_a_pin2_interrupt = o_request_vec[8*1 + ierb_pkg::PORT_A_PIN2_PENDING_BIT];
    assign port_b_pin0_interrupt = o_request_vec[8*1 + ierb_pkg::PORT_B_PIN0_PENDING_BIT];
    assign port_b_pin1_interrupt = o_request_vec[8*1 + ierb_pkg::PORT_B_PIN1_PENDING_BIT];

    // byte 2: converter
    assign converter_interrupt = o_request_vec[8*2 + ierb_pkg::CONVERTER_IRQ_PENDING_BIT];

    // byte 3: timer pair
    assign timer_eight_interrupt = o_request_vec[8*3 + ierb_pkg::TIMER_EIGHT_PENDING_BIT];
    assign timer_nine_interrupt  = o_request_vec[8*3 + ierb_pkg::TIMER_NINE_PENDING_BIT];

    // byte 4: uart and comparators
    assign uart_interrupt            = o_request_vec[8*4 + ierb_pkg::UART_PENDING_BIT];
    assign comparator_zero_interrupt = o_request_vec[8*4 + ierb_pkg::COMPARATOR_ZERO_IRQ_EN_BIT];
    assign comparator_one_interrupt  = o_request_vec[8*4 + ierb_pkg::COMPARATOR_ONE_IRQ_EN_BIT];

    // byte 5: timer group
    assign timer_e_interrupt = o_request_vec[8*5 + ierb_pkg::TIMER_E_IRQ_EN_BIT];
    assign timer_f_interrupt = o_request_vec[8*5 + ierb_pkg::TIMER_F_IRQ_EN_BIT];
    assign timer_a_interrupt = o_request_vec[8*5 + ierb_pkg::TIMER_A_IRQ_EN_BIT];
    assign timer_b_interrupt = o_request_vec[8*5 + ierb_pkg::TIMER_B_IRQ_EN_BIT];

    // byte 6: pwm and fast ticks
    assign pwm_c_interrupt      = o_request_vec[8*6 + ierb_pkg::PWM_C_IRQ_EN_BIT];
    assign tick_128hz_interrupt = o_request_vec[8*6 + ierb_pkg::TICK_128HZ_IRQ_EN_BIT];
    assign tick_32hz_interrupt  = o_request_vec[8*6 + ierb_pkg::TICK_32HZ_IRQ_EN_BIT];

    // byte 7: slow ticks
    assign tick_16hz_interrupt = o_request_vec[8*7 + ierb_pkg::TICK_16HZ_IRQ_EN_BIT];
    assign tick_2hz_interrupt  = o_request_vec[8*7 + ierb_pkg::TICK_2HZ_IRQ_EN_BIT];

    // the cpu sees one non-maskable line and one line for all the rest
    assign o_nmi_request = watchdog_interrupt;

    // the maskable sources are named one by one so no reserved bit can join
    assign o_irq_request = supply_monitor_interrupt
                         // byte 1
                         | port_a_pin0_interrupt
                         | port_a_pin1_interrupt
                         | port_a_pin2_interrupt
                         | port_b_pin0_interrupt
                         | port_b_pin1_interrupt
                         // byte 2
                         | converter_interrupt
                         // byte 3
                         | timer_eight_interrupt
                         | timer_nine_interrupt
                         // byte 4
                         | uart_interrupt
                         | comparator_zero_interrupt
                         | comparator_one_interrupt
                         // byte 5
                         | timer_e_interrupt
                         | timer_f_interrupt
                         | timer_a_interrupt
                         | timer_b_interrupt
                         // byte 6
                         | pwm_c_interrupt
                         | tick_128hz_interrupt
                         | tick_32hz_interrupt
                         // byte 7
                         | tick_16hz_interrupt
                         | tick_2hz_interrupt;

    ////////////////////////////////////////////////////////////////////
    // read path: data one cycle after the strobe, zero elsewhere
    // returning zero outside read cycles lets several slaves share an or-bus

    logic [7:0] rd_byte;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    assign rd_byte = acc_sel[3] ? flag_q[8*acc_sel[2:0] +: 8] : en_q[8*acc_sel[2:0] +: 8];
    assign rdata_d = rd_hit ? rd_byte : 8'h00;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

endmodule : ierb_top

// file: bench/ierb_assertions.sv
// port checker for the enable and request bank
// assumes one clock i_clk and async reset i_rst
module ierb_assertions (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [15:0] i_addr,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_accept,
    input wire logic [7:0]  o_rdata,
    input wire logic        o_master_irq_enable,
    input wire logic        o_nmi_request,
    input wire logic        o_irq_request,
    input wire logic [63:0] o_request_vec,
    input wire logic        o_write_hold
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////
    // read data, masking and hold relations
    property p_ie5; i_rd && i_addr == 16'hf015 |=> o_rdata[3:0] == 4'h0; endproperty
    a_ie5: assert property (p_ie5) else $error("low nibble set");
    property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_acc; i_accept |=> !o_master_irq_enable; endproperty
    a_acc: assert property (p_acc) else $error("master stays on");
    property p_mask; o_irq_request |-> o_master_irq_enable && !o_write_hold; endproperty
    a_mask: assert property (p_mask) else $error("unmasked request");
    property p_nmi; o_nmi_request == o_request_vec[0]; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi mismatch");
    property p_hold; i_wr && i_addr[15:4] == 12'hf01 |=> o_write_hold; endproperty
    a_hold: assert property (p_hold) else $error("no hold");
    property p_held; o_write_hold |-> o_request_vec == 64'h0 && !o_irq_request; endproperty
    a_held: assert property (p_held) else $error("request in hold");
    property p_vec; (o_request_vec & ~ierb_pkg::IRQ_IMPL_MASK) == 64'h0; endproperty
    a_vec: assert property (p_vec) else $error("reserved request");
    c_nmi: cover property (i_accept && o_nmi_request);
    c_irq: cover property (o_irq_request);
    c_rel: cover property (o_write_hold ##1 !o_write_hold);
endmodule : ierb_assertions
////////////////////////////////////////////////////////////////////////////
bind ierb_top ierb_assertions u_chk (.i_clk, .i_rst, .i_addr, .i_wr, .i_rd, .i_accept, .o_rdata,
    .o_master_irq_enable, .o_nmi_request, .o_irq_request, .o_request_vec, .o_write_hold);

// file: bench/ierb_cpu_model.sv
// cpu core stand-in: retires instructions, accepts requests
// assumes request outputs settle within one cycle
module ierb_cpu_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_go,
    input  wire logic        i_irq,
    input  wire logic        i_nmi,
    input  wire logic [63:0] i_vec,
    output logic             o_retire,
    output logic             o_accept,
    output logic      [5:0]  o_index
);
    timeunit 1ns;
    timeprecision 1ps;
    // lowest index wins; gap cycle after accept lets the flag drop first
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_retire <= 1'b0;
            o_accept <= 1'b0;
            o_index  <= 6'h00;
        end else begin
            o_retire <= i_go & ~o_retire;
            o_accept <= i_go & ~o_accept & (i_irq | i_nmi);
            for (int b = 63; b >= 0; b--) begin
                if (i_vec[b]) o_index <= 6'(b);
            end
        end
    end
endmodule : ierb_cpu_model

// file: bench/test_irq_enable_request_bank.sv
// self-checking bench for the enable and request bank
// assumes the cpu model beside it and the bound checker
module test_irq_enable_request_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, go = 1'b0, rd_q = 1'b0;
    logic        i_mie_set = 1'b0, i_mie_clear = 1'b0, retire, acc, master_irq_enable, nmi, irq, hold;
    logic [15:0] i_addr = 16'h0;
    logic [7:0]  i_wdata = 8'h00, o_rdata, d;
    logic [63:0] i_src_event = 64'h0, vec;
    logic [5:0]  idx;
    logic [7:0]  exp_q[$];
    int          fails = 0, checks = 0, cyc = 0;
    ierb_top DUT (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_src_event, .i_mie_set,
        .i_mie_clear, .i_instr_retire(retire), .i_accept(acc), .i_accept_index(idx),
        .o_master_irq_enable(master_irq_enable), .o_nmi_request(nmi), .o_irq_request(irq), .o_request_vec(vec),
        .o_write_hold(hold));
    ierb_cpu_model u_cpu (.i_clk, .i_rst, .i_go(go), .i_irq(irq), .i_nmi(nmi), .i_vec(vec),
        .o_retire(retire), .o_accept(acc), .o_index(idx));
    always #2 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] e);
        checks++;
        if (seen !== e) begin
            fails++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, e);
        end
    endtask : chk
    task complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask : rd
    // one-cycle pulses on events and master enable controls
    task poke(input logic [63:0] e, input logic s, input logic c);
        @(posedge i_clk);
        {i_src_event, i_mie_set, i_mie_clear} <= {e, s, c};
        @(posedge i_clk);
        {i_src_event, i_mie_set, i_mie_clear} <= 66'h0;
    endtask : poke
    // bounded wait for the model's accept, then let the clear land
    task wait_acc;
        bit got;
        got = 1'b0;
        repeat (40) begin
            @(posedge i_clk);
            if (acc === 1'b1) begin
                got = 1'b1;
                break;
            end
        end
        if (!got) fails++;
        repeat (2) @(posedge i_clk);
    endtask : wait_acc
    ////////////////////////////////////////////////////////////////////////
    // read data stand one cycle only, so compare on the falling edge
    always @(posedge i_clk) begin
        rd_q <= i_rd;
        cyc++;
        if (cyc > 2000) begin
            fails++;
            complete_run();
        end
    end
    always @(negedge i_clk) begin
        if (rd_q) chk(o_rdata, exp_q.pop_front());
    end
    // reset values, all ones, random; f020 is unmapped
    initial begin
        void'($urandom(32'hf64b3015));
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            for (int a = 0; a < 17; a++) begin
                d = (p == 0) ? 8'h00 : (p == 1) ? 8'hff : 8'($urandom);
                if (p > 0) wr(16'hf010 + 16'(a), d);
                rd(16'hf010 + 16'(a), a > 15 ? 8'h00 : d & 8'((a < 8 ? ierb_pkg::IE_IMPL_MASK :
                    ierb_pkg::IRQ_IMPL_MASK) >> (8 * (a % 8))));
            end
            $display("test %0d done", p);
        end
        for (int a = 0; a < 16; a++) wr(16'hf010 + 16'(a), 8'h00);
        go <= 1'b1;
        // masked flag stays, enabled one is taken, enables kept
        wr(16'hf015, 8'h10);
        poke(64'h0, 1'b1, 1'b0);
        poke(64'h1 << 45, 1'b0, 1'b0);
        repeat (4) @(posedge i_clk);
        #1 chk(irq, 1'b0);
        chk(vec[47:40], 8'h00);
        rd(16'hf01d, 8'h20);
        poke(64'h1 << 44, 1'b0, 1'b0);
        wait_acc();
        chk(master_irq_enable, 1'b0);
        rd(16'hf01d, 8'h20);
        rd(16'hf015, 8'h10);
        // software-set flag is an event, held back one instruction
        poke(64'h0, 1'b1, 1'b0);
        wr(16'hf01d, 8'h30);
        #1 chk(hold, 1'b1);
        chk(irq, 1'b0);
        wait_acc();
        rd(16'hf01d, 8'h20);
        // watchdog taken with master enable off
        poke(64'h1, 1'b0, 1'b1);
        #1 chk(nmi, 1'b1);
        wait_acc();
        rd(16'hf018, 8'h00);
        $display("test 3 done");
        repeat (3) @(posedge i_clk);
        complete_run();
    end
endmodule : test_irq_enable_request_bank
